//--- common/fdr_pkg.sv
// Package for the fractional delay ramp generator: widths, timing counts,
// mode codes and the carriers between the model processor and the generator.
// Assumes one 125 MHz system clock; UPD_MS, MODE_64 and MODE_512 are not used by the design.
package fdr_pkg;

  // Clock and transform timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TCYC_US = 16;
  localparam int TCYC_CLKS_DEF = (TCYC_US * 1000000) / CLK_PERIOD_PS;
  localparam int UPD_MS = 4;
  // One update period is taken as 256 whole transform cycles
  localparam int UPD_TCYCS = 256;

  // Coefficient widths and positions
  localparam int COEF_W = 20;
  localparam int INT_W = 16;
  localparam int FRAC_IN_W = 32;
  localparam int RATE_IN_W = 64;
  localparam int FRAC_KEEP_LSB = FRAC_IN_W - (COEF_W - 1);
  localparam int RATE_KEEP_LSB = RATE_IN_W - COEF_W;
  localparam logic [COEF_W-1:0] PHASE_OFFSET = 20'h00000;

  // Output shift and serial framing
  localparam int SLOPE_SHIFT = 5;
  localparam int PIPE_SHIFT = 8;
  localparam int SER_LANES_DEF = 10;
  localparam int SER_BITS = 2 * COEF_W;
  localparam logic [5:0] SER_LAST = 6'h27;

  // Mode shift codes: transform size is 64 << code
  localparam logic [2:0] MODE_64 = 3'h0;
  localparam logic [2:0] MODE_512 = 3'h3;
  localparam logic [2:0] MODE_1K = 3'h4;
  localparam logic [2:0] MODE_2K = 3'h5;

  // Fixed-point delay and rate as delivered by the floating point unit
  typedef struct packed {
    logic [INT_W-1:0] int_part;
    logic [FRAC_IN_W-1:0] frac;
    logic [RATE_IN_W-1:0] rate;
    logic [2:0] mode_shift_code;
  } fdr_coef_type;

  // Coefficients as held by the generator
  typedef struct packed {
    logic [INT_W-1:0] int_part;
    logic [COEF_W-1:0] phase;
    logic [COEF_W-1:0] rate;
    logic [2:0] mode_shift_code;
  } fdr_act_type;

  typedef enum logic [1:0] {
    FDR_IDLE = 2'b00,
    FDR_SHIFT = 2'b01
  } fdr_state_type;

endpackage

//--- design/fdr_ramp_gen.sv
// Fractional delay two-coefficient ramp generator on the transform control card.
// Assumes fixed-point coefficients from the floating_point_unit and a transform
// card that accumulates the shifted-out slope in its own oscillators.
`timescale 1ns/1ps

// Function
// (RULE_01) Fresh coefficients requested every 4 ms update
// (RULE_02) Integer signed, fraction always positive
// (RULE_03) 16-bit integer goes to playback port
// (RULE_04) Keep top 20 fraction bits as phase; code keeps the top 19 below a zero sign bit
// (RULE_05) Keep top 20 rate bits
// (RULE_06) New 20-bit slope every 16 us
// (RULE_07) Signed fraction, sign before binary point
// (RULE_08) Zero offset, phase sign stays zero
// (RULE_09) Oscillator wraps modulo one turn
// (RULE_10) Upper 8 bits linear in delay
// (RULE_11) Rate added once per transform cycle
// (RULE_12) Mode code 0..5 selects size
// (RULE_13) Oscillator rate follows transform size
// (RULE_14) Mode shift applied to both coefficients
// (RULE_15) Slope shifted right five more places
// (RULE_16) Oscillator stepping gated by clock enable
// (RULE_17) Each extra pipeline gets initial phase
// (RULE_18) Slope scaled by transform size
// (RULE_19) Top 8 bits address correction ROM
// (RULE_20) Phase scaled 2^32, rate 2^63
// (RULE_21) Serial LSB first, 40 clocks
// (RULE_22) Rate doubled for 1K and 2K
// (RULE_23) 2K pipelines two, three continue phase
// (RULE_24) Single pipeline initial phase zero
// (RULE_25) Coefficients change only at boundaries
module fdr_ramp_gen
  import fdr_pkg::*;
#(
  parameter int LANES = SER_LANES_DEF,
  parameter int TCYC_CLKS = TCYC_CLKS_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire fdr_coef_type coef_in,
  input wire logic coef_valid,
  output logic coef_req,
  output logic [INT_W-1:0] int_delay,
  output logic int_valid,
  output logic [2:0] mode_shift_code,
  output logic ser_frame,
  output logic [LANES-1:0] ser_lane
);

  ////////////////////////////////////////////////////////////////////////////
  // Input conversion

  // Clamp, keep top bits, apply the mode shift to both coefficients
  function automatic fdr_act_type conv(input fdr_coef_type c);
    fdr_act_type a;
    logic [2:0] m;
    m = (c.mode_shift_code > MODE_2K) ? MODE_2K : c.mode_shift_code; // RULE_12
    a.int_part = c.int_part; // RULE_02 RULE_03
    // Sign bit forced clear, fraction top bits below it; input scaled by 2^32
    a.phase = {1'b0, c.frac[FRAC_IN_W-1:FRAC_KEEP_LSB]} + PHASE_OFFSET; // RULE_04 RULE_07 RULE_08 RULE_20
    a.rate = c.rate[RATE_IN_W-1:RATE_KEEP_LSB]; // RULE_05 RULE_20
    a.phase = a.phase >> m; // RULE_14 RULE_18
    a.rate = COEF_W'($signed(a.rate) >>> m); // RULE_14 RULE_18
    a.mode_shift_code = m;
    return a;
  endfunction

  // Slope as the transform card oscillator sees it
  function automatic logic [COEF_W-1:0] slope_of(input logic [COEF_W-1:0] acc, input logic [2:0] m);
    logic [COEF_W-1:0] s;
    s = COEF_W'($signed(acc) >>> SLOPE_SHIFT); // RULE_15
    // Doubling leaves a zero lsb; too small to reach the ROM bits
    if (m >= MODE_1K) begin
      s = {s[COEF_W-2:0], 1'b0}; // RULE_22
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Transform cycle timing

  logic [15:0] tcnt_ff, nxt_tcnt;
  logic [7:0] tidx_ff, nxt_tidx;
  logic tick, boundary;

  assign tick = (tcnt_ff == 16'(TCYC_CLKS - 1));
  assign boundary = tick && (tidx_ff == 8'(UPD_TCYCS - 1));

  // Free running 16 us and 4 ms counters
  always_comb begin
    nxt_tcnt = tick ? 16'h0000 : tcnt_ff + 16'h0001;
    nxt_tidx = tick ? tidx_ff + 8'h01 : tidx_ff;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tcnt_ff <= 16'h0000;
      tidx_ff <= 8'hff;
    end else begin
      tcnt_ff <= nxt_tcnt;
      tidx_ff <= nxt_tidx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coefficient holding

  fdr_act_type pend_ff, nxt_pend, act_ff, nxt_act;
  logic req_ff, nxt_req, ivld_ff, nxt_ivld;

  // Pending copy takes any arrival; active copy moves only at the boundary
  always_comb begin
    nxt_pend = coef_valid ? conv(coef_in) : pend_ff;
    nxt_act = boundary ? pend_ff : act_ff; // RULE_25
    nxt_req = boundary; // RULE_01
    nxt_ivld = boundary; // RULE_03
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_ff <= '0;
      act_ff <= '0;
      req_ff <= 1'b0;
      ivld_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      act_ff <= nxt_act;
      req_ff <= nxt_req;
      ivld_ff <= nxt_ivld;
    end
  end

  assign coef_req = req_ff;
  assign int_valid = ivld_ff;
  assign int_delay = act_ff.int_part; // RULE_03
  assign mode_shift_code = act_ff.mode_shift_code; // RULE_13 RULE_16

  ////////////////////////////////////////////////////////////////////////////
  // Phase accumulation

  logic [COEF_W-1:0] acc_ff, nxt_acc;

  // Load phase at the boundary, else add the rate once per transform cycle
  always_comb begin
    nxt_acc = acc_ff;
    if (boundary) begin
      nxt_acc = pend_ff.phase;
    end else if (tick) begin
      nxt_acc = acc_ff + act_ff.rate; // RULE_11
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output to the transform card

  fdr_state_type st_ff, nxt_st;
  logic frame_ff, nxt_frame;
  logic [5:0] bit_ff, nxt_bit;
  logic [SER_BITS-1:0] sh_ff [LANES];
  logic [SER_BITS-1:0] nxt_sh [LANES];
  logic [COEF_W-1:0] slope, init_256, init_512;

  // Slope taken from the phase just after this cycle's update
  assign slope = slope_of(nxt_acc, nxt_act.mode_shift_code); // RULE_06
  assign init_256 = {slope[COEF_W-1-PIPE_SHIFT:0], PIPE_SHIFT'(0)};
  assign init_512 = {slope[COEF_W-2-PIPE_SHIFT:0], (PIPE_SHIFT + 1)'(0)};

  // Frame sequencer: 40 clocks per load
  always_comb begin
    nxt_st = st_ff;
    nxt_bit = bit_ff;
    case (st_ff)
      FDR_IDLE: begin
        if (tick) begin
          nxt_st = FDR_SHIFT;
          nxt_bit = 6'h00;
        end
      end
      FDR_SHIFT: begin
        nxt_bit = bit_ff + 6'h01;
        if (bit_ff == SER_LAST) begin
          nxt_st = FDR_IDLE; // RULE_21
        end
      end
      default: nxt_st = FDR_IDLE;
    endcase
    // Frame marker registered so the port comes straight from a flop
    nxt_frame = (nxt_st == FDR_SHIFT); // RULE_21
  end

  // One lane per pipeline: initial phase first, then slope, lsb first
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [COEF_W-1:0] init_p;
    always_comb begin
      init_p = '0; // RULE_24
      if (act_ff.mode_shift_code == MODE_1K || nxt_act.mode_shift_code == MODE_1K) begin
        init_p = (l == 1) ? init_256 : '0; // RULE_17
      end
      if (nxt_act.mode_shift_code == MODE_2K) begin
        // Upper pipelines pick up where pipelines 0 and 1 end
        if (l == 1 || l == 2) begin
          init_p = init_256; // RULE_17 RULE_23
        end else if (l == 3) begin
          init_p = init_512; // RULE_23
        end
      end
      if (nxt_act.mode_shift_code < MODE_1K || l > 3) begin
        init_p = '0;
      end
      if (tick) begin
        nxt_sh[l] = {slope, init_p}; // RULE_06
      end else if (st_ff == FDR_SHIFT) begin
        nxt_sh[l] = {1'b0, sh_ff[l][SER_BITS-1:1]}; // RULE_21
      end else begin
        nxt_sh[l] = sh_ff[l];
      end
    end
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        sh_ff[l] <= '0;
      end else begin
        sh_ff[l] <= nxt_sh[l];
      end
    end
    assign ser_lane[l] = sh_ff[l][0];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_ff <= FDR_IDLE;
      bit_ff <= 6'h00;
      frame_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      bit_ff <= nxt_bit;
      frame_ff <= nxt_frame;
    end
  end

  assign ser_frame = frame_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_phase_sign: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    !act_ff.phase[COEF_W-1]) else $error("active phase sign bit set");
  a_coef_hold: assert property (@(posedge clock) disable iff (!rst_n) // RULE_25
    !boundary |=> $stable(act_ff)) else $error("coefficients changed mid update");
  a_rate_step: assert property (@(posedge clock) disable iff (!rst_n) // RULE_11
    tick && !boundary |=> acc_ff == $past(acc_ff) + $past(act_ff.rate)) else $error("rate step wrong");
  a_bound_load: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
    boundary |=> acc_ff == act_ff.phase && coef_req && int_valid) else $error("boundary load wrong");
  a_frame_len: assert property (@(posedge clock) disable iff (!rst_n) // RULE_21
    tick |=> ser_frame && bit_ff == 6'h00 ##39 ser_frame ##1 !ser_frame) else $error("frame not 40 clocks");
  a_slope_load: assert property (@(posedge clock) disable iff (!rst_n) // RULE_15
    tick |=> sh_ff[0][SER_BITS-1:COEF_W] == slope_of(acc_ff, act_ff.mode_shift_code)) else $error("slope wrong");
  a_pipe0_zero: assert property (@(posedge clock) disable iff (!rst_n) // RULE_24
    tick |=> sh_ff[0][COEF_W-1:0] == '0) else $error("pipeline 0 phase not zero");
  a_mode_range: assert property (@(posedge clock) disable iff (!rst_n) // RULE_12
    act_ff.mode_shift_code <= MODE_2K) else $error("mode code out of range");
  a_tick_gap: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
    tick |=> !tick [*8]) else $error("transform cycles too close");

  c_boundary: cover property (@(posedge clock) disable iff (!rst_n) boundary);
  c_mode_2k: cover property (@(posedge clock) disable iff (!rst_n) tick && act_ff.mode_shift_code == MODE_2K);
  c_neg_rate: cover property (@(posedge clock) disable iff (!rst_n) tick && act_ff.rate[COEF_W-1]);
  c_wrap: cover property (@(posedge clock) disable iff (!rst_n) tick && acc_ff[COEF_W-1]);

endmodule

//--- testbench/fdr_osc_model.sv
// Far-end oscillator model: deserialises the generator frames per lane
// and steps a lane 0 accumulator. Assumes one clock shared with the generator.
`timescale 1ns/1ps
module fdr_osc_model
  import fdr_pkg::*;
#(
  parameter int LANES = SER_LANES_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ser_frame,
  input wire logic [LANES-1:0] ser_lane,
  output logic [LANES-1:0][SER_BITS-1:0] word_ff,
  output logic [7:0] rom_addr,
  output int frames_ff,
  output int bad_len_ff
);
  logic [LANES-1:0][SER_BITS-1:0] sh_ff, nxt_sh, nxt_word;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [COEF_W-1:0] acc_ff, nxt_acc;
  int nxt_frames, nxt_bad_len;
  ////////////////////////////////////////////////////////////////////////
  // Capture LSB first, then reload phase; stepping every clock is the fastest enable
  always_comb begin
    nxt_sh = sh_ff;
    nxt_word = word_ff;
    nxt_cnt = cnt_ff;
    nxt_frames = frames_ff;
    nxt_bad_len = bad_len_ff;
    nxt_acc = acc_ff + word_ff[0][SER_BITS-1:COEF_W];
    if (ser_frame) begin
      for (int l = 0; l < LANES; l++) nxt_sh[l] = {ser_lane[l], sh_ff[l][SER_BITS-1:1]};
      nxt_cnt = cnt_ff + 6'h01;
    end else if (cnt_ff != 6'h00) begin
      nxt_word = sh_ff;
      nxt_frames = frames_ff + 1;
      nxt_cnt = 6'h00;
      if (cnt_ff != 6'h28) nxt_bad_len = bad_len_ff + 1;
      nxt_acc = sh_ff[0][COEF_W-1:0];
    end
  end
  // Registers only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sh_ff <= '0;
      word_ff <= '0;
      cnt_ff <= 6'h00;
      frames_ff <= 0;
      bad_len_ff <= 0;
      acc_ff <= '0;
    end else begin
      sh_ff <= nxt_sh;
      word_ff <= nxt_word;
      cnt_ff <= nxt_cnt;
      frames_ff <= nxt_frames;
      bad_len_ff <= nxt_bad_len;
      acc_ff <= nxt_acc;
    end
  end
  // Top bits only reach the correction table, wrap is harmless
  assign rom_addr = acc_ff[COEF_W-1:COEF_W-8];
endmodule

//--- testbench/tb_fractional_delay_ramp_generator.sv
// Self-checking bench for the ramp generator with a short transform cycle.
// Assumes the far-end model file is compiled before this one.
`timescale 1ns/1ps
module tb_fractional_delay_ramp_generator import fdr_pkg::*;;
  localparam int TC = 50;
  localparam int LN = SER_LANES_DEF;
  localparam int LIMIT = 90000;
  logic clock, rst_n, coef_valid, coef_req, int_valid, ser_frame;
  fdr_coef_type coef_in;
  logic [INT_W-1:0] int_delay;
  logic [2:0] mode_shift_code;
  logic [LN-1:0] ser_lane;
  logic [LN-1:0][SER_BITS-1:0] word;
  int frames, bad_len, bad_count, n_checks, cyc;

  fdr_ramp_gen #(.LANES(LN), .TCYC_CLKS(TC)) uut (.clock(clock), .rst_n(rst_n), .coef_in(coef_in),
    .coef_valid(coef_valid), .coef_req(coef_req), .int_delay(int_delay), .int_valid(int_valid),
    .mode_shift_code(mode_shift_code), .ser_frame(ser_frame), .ser_lane(ser_lane));
  fdr_osc_model #(.LANES(LN)) far_end (.clock(clock), .rst_n(rst_n), .ser_frame(ser_frame),
    .ser_lane(ser_lane), .word_ff(word), .rom_addr(), .frames_ff(frames), .bad_len_ff(bad_len));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [SER_BITS-1:0] seen, input logic [SER_BITS-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded waits; a miss shows up as a mismatch afterwards
  task automatic wait_req();
    for (int i = 0; i < 256 * TC + 100 && coef_req !== 1'b1; i++) @(negedge clock);
  endtask
  task automatic wait_frame();
    int f0;
    f0 = frames;
    for (int i = 0; i < 60 && frames == f0; i++) @(negedge clock);
  endtask
  // Expected frame on every lane for one accumulator value
  task automatic frame_check(input logic [2:0] m, input logic [COEF_W-1:0] acc);
    logic [COEF_W-1:0] sl, ini;
    sl = COEF_W'($signed(acc) >>> SLOPE_SHIFT);
    if (m >= MODE_1K) sl = {sl[COEF_W-2:0], 1'b0};
    for (int l = 0; l < LN; l++) begin
      ini = '0;
      if ((m == MODE_1K && l == 1) || (m == MODE_2K && (l == 1 || l == 2))) ini = sl << PIPE_SHIFT;
      if (m == MODE_2K && l == 3) ini = sl << (PIPE_SHIFT + 1);
      check(word[l], {sl, ini});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic reset_check();
    check(40'({coef_req, int_valid, ser_frame, mode_shift_code, int_delay, ser_lane}), 40'h0);
  endtask
  // Every mode code plus one out of range, a decoy overwritten back to back, signs alternating
  task automatic mode_sweep();
    fdr_coef_type c;
    logic [COEF_W-1:0] ph, rt;
    logic [2:0] em;
    for (int i = 0; i < 7; i++) begin
      c.int_part = 16'hfff0 + 16'(i);
      c.frac = 32'h9abc_d000 ^ (32'(i) << 27);
      c.rate = (i % 2 == 1) ? 64'hfff8_4000_0000_0000 : 64'h0012_3000_0000_0000;
      c.mode_shift_code = (i == 6) ? 3'h7 : 3'(i);
      // Codes above the largest size act as the largest size
      em = (i == 6) ? MODE_2K : 3'(i);
      @(negedge clock);
      coef_in = ~c;
      coef_valid = 1'b1;
      @(negedge clock);
      coef_in = c;
      @(negedge clock);
      coef_valid = 1'b0;
      ph = {1'b0, c.frac[FRAC_IN_W-1:FRAC_KEEP_LSB]} >> em;
      rt = COEF_W'($signed(c.rate[RATE_IN_W-1:RATE_KEEP_LSB]) >>> em);
      wait_req();
      check(40'({coef_req, int_valid, mode_shift_code, int_delay}), 40'({2'b11, em, c.int_part}));
      wait_frame();
      frame_check(em, ph);
      wait_frame();
      frame_check(em, ph + rt);
      check(40'({coef_req, int_valid, int_delay}), 40'({2'b00, c.int_part}));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    coef_valid = 1'b0;
    coef_in = '0;
    bad_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (2) @(negedge clock);
    reset_check();
    rst_n = 1'b1;
    mode_sweep();
    check(40'(bad_len), 40'h0);
    end_of_test();
  end
endmodule
